// >>> verilog/dll_pkg.sv
// Purpose: Shared constants for the delay-locked loop behavioural block
// Assumes: System clock of 200 MHz samples the reference clock pin
// Notes:   All timing figures are converted to system clock cycles here
`default_nettype none
package dll_pkg;
   localparam int          CLK_PERIOD_PS  = 5000;
   localparam int          DRIFT_PS       = 1000;
   localparam int          DRIFT_RAW      = DRIFT_PS / CLK_PERIOD_PS;
   localparam logic [7:0]  DRIFT_CYC      = (DRIFT_RAW < 1) ? 8'h01 : DRIFT_RAW[7:0];
   localparam logic [7:0]  MIN_PERIOD_CYC = 8'h08;
   localparam logic [7:0]  MAX_PERIOD_CYC = 8'hc8;
   localparam logic [7:0]  GAP_SAT        = 8'hff;
   localparam logic [2:0]  LOCK_MATCH     = 3'h4;
   localparam logic [8:0]  INSERT_CYC     = 9'h003;
   localparam int          LINE_AW        = 9;
   localparam logic [2:0]  STEP_LAST      = 3'h7;
   localparam logic [2:0]  DIV_RESET_SEL  = 3'h1;
   localparam logic [6:0]  DIV_EVT_TABLE [8] = '{7'h06, 7'h08, 7'h0a, 7'h0c, 7'h10, 7'h14, 7'h20, 7'h40};
   typedef enum logic {DLL_ACQUIRE, DLL_LOCKED} dll_state_t;
endpackage : dll_pkg
`default_nettype wire

// >>> verilog/dll_divider.sv
// Purpose: Fractional clock divider driven by phase-output transition counts
// Assumes: Eight transitions of the four phase outputs make one input period
// Notes:   Ratio n toggles every 4n transitions, so half ratios need no second clock
`timescale 1ns/10ps
`default_nettype none
module dll_divider
   import dll_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       clk_en,
   input  wire logic [2:0] evt_count,
   input  wire logic [2:0] ratio_sel,
   output var  logic       clkdv_reg
);
   logic [6:0] acc_reg;
   logic [7:0] sum;
   logic [6:0] limit;
   logic [7:0] rem;

   assign limit = DIV_EVT_TABLE[ratio_sel];
   assign sum   = {1'b0, acc_reg} + {5'h00, evt_count};
   assign rem   = 8'(sum - {1'b0, limit});

   always_ff @(posedge clk) begin
      if (reset) begin
         acc_reg   <= 7'h00;
         clkdv_reg <= 1'b0;
      end else if (clk_en) begin
         if (sum >= {1'b0, limit}) begin  // [R13]
            // A ratio lowered mid-count could leave a remainder past the new limit
            acc_reg   <= (rem >= {1'b0, limit}) ? 7'h00 : rem[6:0];
            clkdv_reg <= ~clkdv_reg;
         end else begin
            acc_reg <= sum[6:0];
         end
      end
   end

   a_div_toggle: assert property (@(posedge clk) disable iff (reset)
      clk_en && (sum < {1'b0, limit}) |=> $stable(clkdv_reg)) // [R13]
      else $error("divided clock toggled before its transition count");
   a_div_acc_bound: assert property (@(posedge clk) disable iff (reset)
      $stable(ratio_sel) |-> acc_reg < limit) // [R13]
      else $error("divider accumulator passed its limit");
endmodule : dll_divider
`default_nettype wire

// >>> verilog/dll_lock.sv
// Purpose: Behavioural delay-locked loop: lock, delay line, phases, start-up hold
// Assumes: Reference clock pin is asynchronous; manual reset comes from clk logic
// Notes:   Output clocks are sampled copies at the system rate, not real clocks
// Contract
// [R1] Optional start-up pause at chosen step until lock
// [R2] Lock holds while period drifts within 1 ns
// [R3] Larger period change needs manual reset by user
// [R4] Stops under 100 us, low phase, full high
// [R5] Lock flag stays high across permitted stops
// [R6] Out-of-spec stop needs manual reset after restart
// [R7] Outputs emit further pulses while delay line flushes
// [R8] Outputs silent briefly while delay line refills
// [R9] Input phase shift reaches outputs undisturbed, later
// [R10] Users ignore output clocks until lock
// [R11] Output clocks are delayed copies of input
// [R12] Delay puts edges one period after pad
// [R13] Quadrature phases, doubled and selectable divided clock
// [R14] Manual reset drops lock and restarts acquisition
`timescale 1ns/10ps
`default_nettype none
module dll_lock
   import dll_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       clk_en,
   input  wire logic       ref_clk_pin,
   input  wire logic       dll_reset,
   input  wire logic [2:0] div_sel,
   input  wire logic       config_done,
   input  wire logic       startup_wait_en,
   input  wire logic [2:0] startup_hold_step,
   output var  logic       locked_reg,
   output var  logic       clk0_reg,
   output var  logic       clk90_reg,
   output var  logic       clk180_reg,
   output var  logic       clk270_reg,
   output var  logic       clk2x_reg,
   output var  logic       clkdv_reg,
   output var  logic       ref_stopped_reg,
   output var  logic [2:0] startup_step_reg,
   output var  logic       startup_done_reg
);
   logic                ref_meta_reg;
   logic                ref_sync_reg;
   logic                ref_prev_reg;
   logic                ref_rise;
   logic [7:0]          gap_reg;
   logic [7:0]          period_reg;
   logic [2:0]          match_reg;
   dll_state_t          state_reg;
   logic [7:0]          drift;
   logic                in_range;
   logic                within_drift;
   logic                line_mem [2**LINE_AW];
   logic [LINE_AW-1:0]  wr_ptr_reg;
   logic [LINE_AW-1:0]  base_delay;
   logic [LINE_AW-1:0]  quarter;
   logic [3:0]          tap;
   logic [2:0]          evt_count;

   // Pin crosses into clk domain; the second and third stages feed logic, the first never does
   always_ff @(posedge clk) begin
      if (reset) begin
         ref_meta_reg <= 1'b0;
         ref_sync_reg <= 1'b0;
         ref_prev_reg <= 1'b0;
      end else if (clk_en) begin
         ref_meta_reg <= ref_clk_pin;
         ref_sync_reg <= ref_meta_reg;
         ref_prev_reg <= ref_sync_reg;
      end
   end

   assign ref_rise     = ref_sync_reg & ~ref_prev_reg;
   assign drift        = (gap_reg > period_reg) ? 8'(gap_reg - period_reg) : 8'(period_reg - gap_reg);
   assign in_range     = (gap_reg >= MIN_PERIOD_CYC) && (gap_reg <= MAX_PERIOD_CYC);
   assign within_drift = in_range && (drift <= DRIFT_CYC);

   // Cycles since the last rising edge; saturation marks a stopped input
   always_ff @(posedge clk) begin
      if (reset) begin
         gap_reg         <= 8'h00;
         ref_stopped_reg <= 1'b0;
      end else if (clk_en) begin
         if (ref_rise) begin
            gap_reg <= 8'h01;
         end else if (gap_reg != GAP_SAT) begin
            gap_reg <= 8'(gap_reg + 8'h01);
         end
         ref_stopped_reg <= (gap_reg == GAP_SAT) && !ref_rise;
      end
   end

   // Acquisition and lock tracking
   always_ff @(posedge clk) begin
      if (reset || (clk_en && dll_reset)) begin
         state_reg  <= DLL_ACQUIRE;  // [R14]
         locked_reg <= 1'b0;         // [R14]
         match_reg  <= 3'h0;
         period_reg <= 8'h00;
      end else if (clk_en && ref_rise) begin
         unique case (state_reg)
            DLL_ACQUIRE: begin
               period_reg <= gap_reg;
               if (within_drift) begin
                  match_reg <= 3'(match_reg + 3'h1);
                  if (match_reg == 3'(LOCK_MATCH - 3'h1)) begin
                     state_reg  <= DLL_LOCKED;  // [R14]
                     locked_reg <= 1'b1;
                  end
               end else begin
                  match_reg <= 3'h0;
               end
            end
            DLL_LOCKED: begin
               // Tracks slow drift; a larger jump or a long stop leaves the flag up
               if (within_drift) begin
                  period_reg <= gap_reg;  // [R2]
               end
               locked_reg <= 1'b1;  // [R5] [R3] [R6]
            end
         endcase
      end
   end

   // Delay line: one sample per cycle, read one period minus insertion back
   assign base_delay = {1'b0, period_reg} - INSERT_CYC;  // [R12]
   assign quarter    = {3'h0, period_reg[7:2]};

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_ptr_reg <= '0;
         // Cleared so unknown samples never reach the taps and lock up the divider
         for (int i = 0; i < 2**LINE_AW; i++) begin
            line_mem[i] <= 1'b0;
         end
      end else if (clk_en) begin
         line_mem[wr_ptr_reg] <= ref_sync_reg;  // [R11]
         wr_ptr_reg           <= LINE_AW'(wr_ptr_reg + 1'b1);
      end
   end

   // Taps at 0, 90, 180 and 270 degrees; a stop or shift flushes through late
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_tap
         logic [LINE_AW-1:0] dly;
         assign dly    = LINE_AW'(base_delay + LINE_AW'(g) * quarter);
         assign tap[g] = line_mem[LINE_AW'(wr_ptr_reg - dly)];  // [R7] [R8] [R9]
      end
   endgenerate

   assign evt_count = 3'(tap[0] ^ clk0_reg) + 3'(tap[1] ^ clk90_reg)
                    + 3'(tap[2] ^ clk180_reg) + 3'(tap[3] ^ clk270_reg);

   always_ff @(posedge clk) begin
      if (reset) begin
         clk0_reg   <= 1'b0;
         clk90_reg  <= 1'b0;
         clk180_reg <= 1'b0;
         clk270_reg <= 1'b0;
         clk2x_reg  <= 1'b0;
      end else if (clk_en) begin
         clk0_reg   <= tap[0];  // [R11] [R13]
         clk90_reg  <= tap[1];
         clk180_reg <= tap[2];
         clk270_reg <= tap[3];
         clk2x_reg  <= tap[0] ^ tap[1];  // [R13]
      end
   end

   dll_divider u_dll_divider (
      .clk       (clk),
      .reset     (reset),
      .clk_en    (clk_en),
      .evt_count (evt_count),
      .ratio_sel (div_sel),
      .clkdv_reg (clkdv_reg)
   );

   // Start-up steps run after configuration; the chosen step may wait for lock
   always_ff @(posedge clk) begin
      if (reset) begin
         startup_step_reg <= 3'h0;
         startup_done_reg <= 1'b0;
      end else if (clk_en && config_done && !startup_done_reg) begin
         if (startup_wait_en && (startup_step_reg == startup_hold_step) && !locked_reg) begin
            startup_step_reg <= startup_step_reg;  // [R1]
         end else if (startup_step_reg == STEP_LAST) begin
            startup_done_reg <= 1'b1;
         end else begin
            startup_step_reg <= 3'(startup_step_reg + 3'h1);
         end
      end
   end

   sequence s_hold_point;
      startup_wait_en && config_done && !startup_done_reg
         && (startup_step_reg == startup_hold_step) && !locked_reg;
   endsequence
   sequence s_lock_match;
      clk_en && !dll_reset && ref_rise && (state_reg == DLL_ACQUIRE) && within_drift
         && (match_reg == 3'(LOCK_MATCH - 3'h1));
   endsequence

   a_startup_pause: assert property (@(posedge clk) disable iff (reset)
      s_hold_point |=> $stable(startup_step_reg) && !startup_done_reg) // [R1]
      else $error("start-up advanced past the hold step without lock");
   a_startup_free: assert property (@(posedge clk) disable iff (reset)
      !startup_wait_en && clk_en && config_done && !startup_done_reg && startup_step_reg != STEP_LAST
      |=> startup_step_reg == 3'($past(startup_step_reg) + 3'h1)) // [R1]
      else $error("start-up stalled while the hold option was off");
   a_drift_track: assert property (@(posedge clk) disable iff (reset)
      clk_en && !dll_reset && ref_rise && locked_reg && within_drift |=> period_reg == $past(gap_reg)) // [R2]
      else $error("locked period did not follow a small drift");
   a_lock_keep: assert property (@(posedge clk) disable iff (reset)
      locked_reg && !(clk_en && dll_reset) |=> locked_reg) // [R5]
      else $error("lock flag fell without a manual reset");
   a_lock_drop: assert property (@(posedge clk) disable iff (reset)
      clk_en && dll_reset |=> !locked_reg ##0 state_reg == DLL_ACQUIRE) // [R14]
      else $error("manual reset did not clear the lock");
   a_lock_rise: assert property (@(posedge clk) disable iff (reset)
      $rose(locked_reg) |-> $past(state_reg) == DLL_ACQUIRE && $past(match_reg) == 3'(LOCK_MATCH - 3'h1)) // [R14]
      else $error("lock flag rose without enough matching periods");
   a_lock_entry: assert property (@(posedge clk) disable iff (reset)
      s_lock_match |=> locked_reg) // [R14]
      else $error("lock not declared after matching periods");
   a_double_clk: assert property (@(posedge clk) disable iff (reset)
      clk_en |=> clk2x_reg == (clk0_reg ^ clk90_reg)) // [R13]
      else $error("doubled clock differs from phase exclusive-or");
   a_copy_delay: assert property (@(posedge clk) disable iff (reset)
      clk_en |=> clk0_reg == $past(tap[0])) // [R11]
      else $error("output clock is not the delayed input sample");
endmodule : dll_lock
`default_nettype wire

// >>> testbench/dll_ref_src.sv
// Purpose: Reference clock source model for the delay-locked loop bench
// Assumes: High and low times are given in system clock cycles
// Notes:   A stop waits for the low phase, so a full high phase follows restart
`timescale 1ns/10ps
`default_nettype none
module dll_ref_src (
   input  wire logic       clk,
   input  wire logic       run,
   input  wire logic [7:0] hi,
   input  wire logic [7:0] lo,
   input  wire logic       shift,
   output var  logic       ref_clk_pin
);
   logic [7:0] cnt_reg;

   initial begin
      ref_clk_pin = 1'b0;
      cnt_reg     = 8'h00;
   end

   // Plain always so the initial block may preset the pin
   always @(posedge clk) begin
      if (!run && !ref_clk_pin) begin
         cnt_reg <= 8'h00; // Stop only in low phase
      end else if (shift) begin
         cnt_reg <= 8'h00; // Stretch current phase to shift the edges
      end else if (cnt_reg >= (ref_clk_pin ? hi : lo) - 8'h01) begin
         cnt_reg     <= 8'h00;
         ref_clk_pin <= ~ref_clk_pin;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end
endmodule : dll_ref_src
`default_nettype wire

// >>> testbench/dll_lock_tb.sv
// Purpose: Self-checking bench for the delay-locked loop block
// Assumes: Reference clock comes from dll_ref_src
// Notes:   Taps are approximate, so outputs are judged by edge counts in windows
`timescale 1ns/10ps
`default_nettype none
module dll_lock_tb;
   import dll_pkg::*;
   logic        clk, reset, clk_en, dll_reset, config_done, startup_wait_en, run, shift;
   logic [2:0]  div_sel, startup_hold_step, startup_step_reg;
   logic [7:0]  hi, lo;
   logic        locked_reg, clk0_reg, clk90_reg, clk180_reg, clk270_reg, clk2x_reg, clkdv_reg;
   logic        ref_stopped_reg, startup_done_reg, ref_clk_pin;
   logic [5:0]  prv;
   logic [15:0] exp_q[$], got_q[$], e_m, g_m;
   int          errors, total_checks, seed, per, n, e;
   int          rises[6];
   wire  [5:0]  cur = {clkdv_reg, clk2x_reg, clk270_reg, clk180_reg, clk90_reg, clk0_reg};

   dll_lock u_dll_lock (.clk(clk), .reset(reset), .clk_en(clk_en), .ref_clk_pin(ref_clk_pin),
      .dll_reset(dll_reset), .div_sel(div_sel), .config_done(config_done),
      .startup_wait_en(startup_wait_en), .startup_hold_step(startup_hold_step),
      .locked_reg(locked_reg), .clk0_reg(clk0_reg), .clk90_reg(clk90_reg), .clk180_reg(clk180_reg),
      .clk270_reg(clk270_reg), .clk2x_reg(clk2x_reg), .clkdv_reg(clkdv_reg),
      .ref_stopped_reg(ref_stopped_reg), .startup_step_reg(startup_step_reg),
      .startup_done_reg(startup_done_reg));
   dll_ref_src u_dll_ref_src (.clk(clk), .run(run), .hi(hi), .lo(lo), .shift(shift),
      .ref_clk_pin(ref_clk_pin));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      for (int i = 0; i < 6; i++) if (cur[i] && !prv[i]) rises[i]++;
      prv = cur;
   end

   always @(posedge clk) begin
      while (got_q.size() > 0 && exp_q.size() > 0) begin
         g_m = got_q.pop_front();
         e_m = exp_q.pop_front();
         total_checks++;
         if (g_m !== e_m) begin
            errors++;
            $display("ERROR t=%0t expected %h got %h", $time, e_m, g_m);
         end
      end
   end

   task step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : step

   task chk(input logic [15:0] ev, input logic [15:0] gv);
      exp_q.push_back(ev);
      got_q.push_back(gv);
   endtask : chk

   task clr();
      rises = '{default: 0};
   endtask : clr

   task wait_lock();
      n = 0;
      while (locked_reg !== 1'b1 && n < 2000) begin
         step(1);
         n++;
      end
   endtask : wait_lock

   task finish_test();
      repeat (2) @(posedge clk);
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test

   initial begin
      #200000;
      errors++;
      $display("ERROR t=%0t watchdog expired", $time);
      finish_test();
   end

   initial begin
      seed              = 57;
      errors            = 0;
      total_checks      = 0;
      prv               = 6'h00;
      clr();
      clk_en            = 1'b1;
      reset             = 1'b1;
      dll_reset         = 1'b0;
      config_done       = 1'b1;
      startup_wait_en   = 1'b1;
      startup_hold_step = 3'($unsigned($random(seed)) % 8);
      div_sel           = 3'h1;
      run               = 1'b0;
      shift             = 1'b0;
      hi                = 8'h09 + 8'($unsigned($random(seed)) % 4);
      lo                = hi;
      per               = hi + lo;
      step(4);
      reset = 1'b0;
      step(1);
      chk(16'h0000, 16'({locked_reg, startup_done_reg}));
      run = 1'b1;
      step(20);
      chk(16'({1'b0, startup_hold_step}), 16'({startup_done_reg, startup_step_reg}));
      wait_lock(); // Outputs are ignored until lock
      chk(16'h0001, 16'(locked_reg));
      step(12);
      chk(16'h0001, 16'(startup_done_reg));
      $display("test startup and lock done");
      while (ref_clk_pin) step(1);
      while (!ref_clk_pin) step(1);
      step(3);
      n = 3;
      clr();
      while (rises[0] == 0 && n < 400) begin
         step(1);
         n++;
      end
      chk(16'h0001, 16'(n >= per - 2 && n <= per + 3));
      for (int d = 0; d < 8; d++) begin
         div_sel = 3'(d);
         step(4 * per);
         clr();
         step(32 * per);
         e = 128 / int'(DIV_EVT_TABLE[d]);
         chk(16'h0001, 16'(rises[5] >= e - 1 && rises[5] <= e + 1));
         chk(16'h0001, 16'(rises[4] >= 62 && rises[4] <= 66));
         chk(16'h0007, 16'({rises[1] >= 31 && rises[1] <= 33, rises[2] >= 31 && rises[2] <= 33,
                            rises[3] >= 31 && rises[3] <= 33}));
      end
      $display("test divider and phases done");
      lo = lo + 8'h01;
      step(4 * per);
      clr();
      step(16 * per);
      chk(16'h0001, 16'(locked_reg && rises[0] >= 14));
      run = 1'b0; // Source stops in its low phase
      while (ref_clk_pin) step(1);
      clr();
      step(4 * per);
      chk(16'h0001, 16'(rises[0] >= 1 && rises[0] <= 4));
      step(300);
      chk(16'h0003, 16'({locked_reg, ref_stopped_reg}));
      clr();
      run = 1'b1;
      n = 0;
      while (rises[0] == 0 && n < 400) begin
         step(1);
         n++;
      end
      chk(16'h0001, 16'(n >= per - 2 && n <= 4 * per + 4));
      chk(16'h0001, 16'(locked_reg));
      dll_reset = 1'b1; // Stop terms not vouched for, so reset after restart
      step(1);
      dll_reset = 1'b0;
      chk(16'h0000, 16'(locked_reg));
      wait_lock();
      chk(16'h0001, 16'(locked_reg));
      $display("test stop and restart done");
      shift = 1'b1;
      step(1);
      shift = 1'b0;
      step(4 * per);
      clr();
      step(8 * per);
      chk(16'h0001, 16'(locked_reg && rises[0] >= 6));
      lo = lo + 8'h0a;
      step(10 * per);
      chk(16'h0001, 16'(locked_reg));
      dll_reset = 1'b1; // Big change needs manual reset
      step(1);
      dll_reset = 1'b0;
      chk(16'h0000, 16'(locked_reg));
      wait_lock();
      chk(16'h0001, 16'(locked_reg));
      $display("test phase shift and relock done");
      reset = 1'b1;
      startup_wait_en = 1'b0;
      step(2);
      reset = 1'b0;
      step(1);
      chk(16'h0001, 16'({locked_reg, startup_done_reg, startup_step_reg}));
      step(2);
      clk_en = 1'b0;
      step(5);
      chk(16'h0003, 16'(startup_step_reg)); // Enable low freezes the sequence
      clk_en = 1'b1;
      step(6);
      chk(16'h0001, 16'({locked_reg, startup_done_reg})); // No wait for lock when option off
      $display("test reset and free start-up done");
      finish_test();
   end
endmodule : dll_lock_tb
`default_nettype wire
